// [common/fsc_consts.svh]
// Constants for the filter serial control block: register layout,
// reset values and decode tables. Included by package and logic files.
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH

// Control word size
`define FSC_WORD_W 8

// Control word bit positions
`define FSC_BIT_GAIN_LSB 7
`define FSC_BIT_GAIN_MSB 6
`define FSC_BIT_CUT_LSB 5
`define FSC_BIT_CUT_MSB 4
`define FSC_BIT_SPARE_HI 3
`define FSC_BIT_SPARE_LO 2
`define FSC_BIT_LOW_POWER 1
`define FSC_BIT_GP_OUT 0

// Reset values
`define FSC_CTRL_RESET 8'h00
`define FSC_SYNC_RESET 7'h7F

// Passband gain per code, in dB
`define FSC_GAIN_DB_W 5
`define FSC_GAIN_DB_00 5'h00
`define FSC_GAIN_DB_01 5'h06
`define FSC_GAIN_DB_10 5'h0C
`define FSC_GAIN_DB_11 5'h18

// Filter clock to bandwidth ratio per cutoff code
`define FSC_RATIO_W 10
`define FSC_RATIO_00 10'h200
`define FSC_RATIO_01 10'h080
`define FSC_RATIO_1X 10'h020

// Clock-source select encodings: bit 1 pin high, bit 0 pin low
`define FSC_CLKSEL_OPEN 2'h0
`define FSC_CLKSEL_GND 2'h1
`define FSC_CLKSEL_HIGH 2'h2

`endif

// [common/fsc_pkg.sv]
// Types shared by the filter serial control block.
// Assumes fsc_consts.svh is on the include path.
`include "fsc_consts.svh"

package fsc_pkg;

    // Master clock source modes
    typedef enum logic [1:0] {
        FSC_SRC_EXTERNAL,
        FSC_SRC_INTERNAL_QUIET,
        FSC_SRC_INTERNAL_DRIVE
    } fsc_clk_src_t;

    // Settings applied to both filter channels
    typedef struct packed {
        logic [1:0] gain_code;
        logic [1:0] cutoff_code;
        logic low_power;
        logic gp_out;
    } fsc_settings_t;

    // Master clock pin and oscillator controls
    typedef struct packed {
        logic osc_enable;
        logic ext_clock_sel;
        logic pin_oe_n;
        logic pin_pulldown;
    } fsc_clk_ctrl_t;

endpackage

// [logic/fsc_sync.sv]
// Two-stage synchroniser for a bundle of slow pin levels.
// Assumes inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/100ps

module fsc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    // First stage feeds only the second
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage_one <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end

endmodule

// [logic/fsc_top.sv]
// Control front end of a dual programmable lowpass filter: pin or
// serial programming, serial shift register, control latch, clock mux.
// Assumes sys_clk_in at 100 MHz; serial clock arrives on the cutoff LSB
// pin and idles low between frames.
`timescale 1ns/100ps
`include "fsc_consts.svh"

module fsc_top (
    // System clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Mode strap
    input wire logic serial_select_n_in,
    // Cutoff pins, shared with chip select and serial clock
    input wire logic cutoff_code_msb_in,
    input wire logic cutoff_code_lsb_in,
    // Serial data
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe_n_out,
    // Gain pins, low bit two-way
    input wire logic gain_code_lsb_in,
    output logic gain_code_lsb_out,
    output logic gain_code_lsb_oe_n_out,
    input wire logic gain_code_msb_in,
    // Clock source select and master clock pin controls
    input wire logic [1:0] clock_source_select_in,
    output fsc_pkg::fsc_clk_src_t clock_source_out,
    output fsc_pkg::fsc_clk_ctrl_t master_clock_ctrl_out,
    // Filter settings for both channels
    output fsc_pkg::fsc_settings_t filter_settings_out,
    output logic [`FSC_GAIN_DB_W-1:0] gain_db_out,
    output logic [`FSC_RATIO_W-1:0] cutoff_ratio_out,
    // Control word and status
    output logic [`FSC_WORD_W-1:0] filter_control_word_out,
    output logic control_update_out,
    output logic serial_mode_out
);

    // Link domain: serial clock on the cutoff LSB pin
    logic [`FSC_WORD_W-1:0] link_shift;
    logic link_sdo;

    // System domain
    logic [6:0] pins_sync;
    logic strap_s;
    logic cs_n_s;
    logic cut_lsb_s;
    logic gain_msb_s;
    logic gain_lsb_s;
    logic [1:0] clk_sel_s;
    logic cs_n_prev;
    logic cs_rise;
    logic serial_mode;
    logic [`FSC_WORD_W-1:0] filter_control_word;
    fsc_pkg::fsc_settings_t next_settings;
    fsc_pkg::fsc_clk_src_t next_clock_source;
    fsc_pkg::fsc_clk_ctrl_t next_clock_ctrl;
    logic [`FSC_GAIN_DB_W-1:0] next_gain_db;
    logic [`FSC_RATIO_W-1:0] next_ratio;

    // ---------------- Link domain ----------------

    // Word crosses to the system clock only on the synchronised select rise;
    // select high holds this shift register, so the word stands still while it crosses
    // Shift in on rising edge while selected
    always_ff @(posedge cutoff_code_lsb_in or posedge rst_in) begin
        if (rst_in) begin
            link_shift <= `FSC_CTRL_RESET;
        end else if (!cutoff_code_msb_in) begin
            // Clean gating relies on clock low when select falls
            link_shift <= {link_shift[`FSC_WORD_W-2:0], serial_data_in};
        end else begin
            link_shift <= link_shift;
        end
    end

    // Serial output on falling edge, MSB stage
    always_ff @(negedge cutoff_code_lsb_in or posedge rst_in) begin
        if (rst_in) begin
            link_sdo <= 1'b0;
        end else if (!cutoff_code_msb_in) begin
            link_sdo <= link_shift[`FSC_WORD_W-1];
        end else begin
            link_sdo <= link_sdo;
        end
    end

    assign serial_data_out = link_sdo;

    // ---------------- System domain ----------------

    // Pin levels into the system clock
    // Order: strap, select, link clock, gain high, gain low, source select
    fsc_sync #(
        .WIDTH(7),
        .RESET_VAL(`FSC_SYNC_RESET)
    ) u_pin_sync (
        .clk_in(sys_clk_in),
        .rst_in(rst_in),
        .async_in({serial_select_n_in,
                   cutoff_code_msb_in,
                   cutoff_code_lsb_in,
                   gain_code_msb_in,
                   gain_code_lsb_in,
                   clock_source_select_in}),
        .sync_out(pins_sync)
    );

    assign strap_s = pins_sync[6];
    assign cs_n_s = pins_sync[5];
    assign cut_lsb_s = pins_sync[4];
    assign gain_msb_s = pins_sync[3];
    assign gain_lsb_s = pins_sync[2];
    assign clk_sel_s = pins_sync[1:0];

    // Chip select edge detection
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cs_n_prev <= 1'b1;
        end else begin
            cs_n_prev <= cs_n_s;
        end
    end

    assign cs_rise = cs_n_s & ~cs_n_prev;

    // Mode from strap: high or open is pin mode
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            serial_mode <= 1'b0;
        end else begin
            serial_mode <= ~strap_s;
        end
    end

    assign serial_mode_out = serial_mode;

    // Control latch; shift register is frozen while select is high
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            filter_control_word <= `FSC_CTRL_RESET;
        end else if (serial_mode && cs_rise) begin
            filter_control_word <= link_shift;
        end else begin
            filter_control_word <= filter_control_word;
        end
    end

    assign filter_control_word_out = filter_control_word;

    // One-cycle pulse when the latch loads
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            control_update_out <= 1'b0;
        end else begin
            control_update_out <= serial_mode & cs_rise;
        end
    end

    // Settings source: latched word or pins
    always_comb begin
        next_settings = '0;
        if (serial_mode) begin
            // Pin-mode code inputs unused here
            next_settings.gain_code = {filter_control_word[`FSC_BIT_GAIN_MSB],
                                       filter_control_word[`FSC_BIT_GAIN_LSB]};
            next_settings.cutoff_code = {filter_control_word[`FSC_BIT_CUT_MSB],
                                         filter_control_word[`FSC_BIT_CUT_LSB]};
            next_settings.low_power = filter_control_word[`FSC_BIT_LOW_POWER];
            next_settings.gp_out = filter_control_word[`FSC_BIT_GP_OUT];
        end else begin
            next_settings.gain_code = {gain_msb_s, gain_lsb_s};
            next_settings.cutoff_code = {cs_n_s, cut_lsb_s};
            next_settings.low_power = 1'b0;
            next_settings.gp_out = 1'b0;
        end
    end

    // Single settings word for both channels
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            filter_settings_out <= '0;
        end else begin
            filter_settings_out <= next_settings;
        end
    end

    // Gain decode in dB
    always_comb begin
        unique case (next_settings.gain_code)
            2'b00: next_gain_db = `FSC_GAIN_DB_00;
            2'b01: next_gain_db = `FSC_GAIN_DB_01;
            2'b10: next_gain_db = `FSC_GAIN_DB_10;
            2'b11: next_gain_db = `FSC_GAIN_DB_11;
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            gain_db_out <= `FSC_GAIN_DB_00;
        end else begin
            gain_db_out <= next_gain_db;
        end
    end

    // Filter clock divided by this ratio gives the bandwidth
    always_comb begin
        unique case (next_settings.cutoff_code)
            2'b00: next_ratio = `FSC_RATIO_00;
            2'b01: next_ratio = `FSC_RATIO_01;
            2'b10: next_ratio = `FSC_RATIO_1X;
            2'b11: next_ratio = `FSC_RATIO_1X;
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cutoff_ratio_out <= `FSC_RATIO_00;
        end else begin
            cutoff_ratio_out <= next_ratio;
        end
    end

    // Gain LSB pin turns output in serial mode
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            gain_code_lsb_out <= 1'b0;
            gain_code_lsb_oe_n_out <= 1'b1;
        end else begin
            gain_code_lsb_out <= filter_control_word[`FSC_BIT_GP_OUT];
            gain_code_lsb_oe_n_out <= ~serial_mode;
        end
    end

    // Serial output enable: driven whenever in serial mode
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            serial_data_oe_n_out <= 1'b1;
        end else begin
            serial_data_oe_n_out <= ~serial_mode;
        end
    end

    // Clock source decode
    always_comb begin
        next_clock_ctrl = '0;
        case (clk_sel_s)
            `FSC_CLKSEL_GND: begin
                next_clock_source = fsc_pkg::FSC_SRC_EXTERNAL;
                next_clock_ctrl.ext_clock_sel = 1'b1;
                next_clock_ctrl.pin_oe_n = 1'b1;
            end
            `FSC_CLKSEL_HIGH: begin
                next_clock_source = fsc_pkg::FSC_SRC_INTERNAL_DRIVE;
                next_clock_ctrl.osc_enable = 1'b1;
                next_clock_ctrl.pin_oe_n = 1'b0;
            end
            default: begin
                // Open pin and the both-high code share this arm
                next_clock_source = fsc_pkg::FSC_SRC_INTERNAL_QUIET;
                next_clock_ctrl.osc_enable = 1'b1;
                next_clock_ctrl.pin_oe_n = 1'b1;
                next_clock_ctrl.pin_pulldown = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            clock_source_out <= fsc_pkg::FSC_SRC_INTERNAL_QUIET;
            master_clock_ctrl_out <= '0;
        end else begin
            clock_source_out <= next_clock_source;
            master_clock_ctrl_out <= next_clock_ctrl;
        end
    end

endmodule

// [sim/fsc_checker.sv]
// Assertions on the filter serial control ports.
// Bound into fsc_top; all checks run on the system clock.
`timescale 1ns/100ps
module fsc_checker (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Pins
    input wire logic serial_select_n_in,
    input wire logic cutoff_code_msb_in,
    input wire logic [1:0] clock_source_select_in,
    // Outputs
    input wire logic serial_data_oe_n_out,
    input wire logic gain_code_lsb_out,
    input wire logic gain_code_lsb_oe_n_out,
    input wire fsc_pkg::fsc_clk_src_t clock_source_out,
    input wire fsc_pkg::fsc_settings_t filter_settings_out,
    input wire logic [4:0] gain_db_out,
    input wire logic [9:0] cutoff_ratio_out,
    input wire logic [7:0] filter_control_word_out,
    input wire logic control_update_out,
    input wire logic serial_mode_out
);
    localparam logic [4:0] GDB [4] = '{5'h00, 5'h06, 5'h0C, 5'h18};
    localparam logic [9:0] RAT [4] = '{10'h200, 10'h080, 10'h020, 10'h020};
    localparam fsc_pkg::fsc_clk_src_t SRC [4] = '{fsc_pkg::FSC_SRC_INTERNAL_QUIET,
        fsc_pkg::FSC_SRC_EXTERNAL, fsc_pkg::FSC_SRC_INTERNAL_DRIVE,
        fsc_pkg::FSC_SRC_INTERNAL_QUIET};
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    mode_entry_a: assert property ($fell(serial_select_n_in) |-> ##[2:4] serial_mode_out)
        else $error("serial mode not entered");
    sdo_drive_a: assert property (serial_mode_out[*3] |-> !serial_data_oe_n_out)
        else $error("serial output released");
    gp_drive_a: assert property (serial_mode_out[*3] |-> !gain_code_lsb_oe_n_out)
        else $error("gain low pin not driven");
    latch_load_a: assert property (serial_mode_out && $rose(cutoff_code_msb_in)
        |-> ##[1:4] control_update_out) else $error("select rise did not load");
    word_map_a: assert property (control_update_out |=> filter_settings_out == {
        filter_control_word_out[6], filter_control_word_out[7], filter_control_word_out[4],
        filter_control_word_out[5], filter_control_word_out[1], filter_control_word_out[0]})
        else $error("settings do not follow word");
    gp_level_a: assert property ($stable(filter_control_word_out)[*3]
        |-> gain_code_lsb_out == filter_control_word_out[0]) else $error("gp level wrong");
    gain_db_a: assert property (gain_db_out == GDB[filter_settings_out.gain_code])
        else $error("gain decode wrong");
    cutoff_ratio_a: assert property (cutoff_ratio_out == RAT[filter_settings_out.cutoff_code])
        else $error("cutoff decode wrong");
    pins_ignored_a: assert property (serial_mode_out[*4] ##0 !control_update_out
        ##1 serial_mode_out |-> $stable(filter_settings_out)) else $error("settings moved");
    clk_src_a: assert property ($stable(clock_source_select_in)[*4]
        |-> clock_source_out == SRC[clock_source_select_in]) else $error("clock source wrong");

    cover property (control_update_out ##1 filter_settings_out.low_power);
    cover property ($rose(serial_mode_out));
    cover property (clock_source_out == fsc_pkg::FSC_SRC_EXTERNAL);
endmodule

bind fsc_top fsc_checker u_chk (.*);

// [sim/fsc_spi_master.sv]
// Serial master model driving select, link clock and data.
// Assumes the testbench calls its tasks; link clock idles low.
`timescale 1ns/100ps
module fsc_spi_master (
    // Link pins
    output logic sclk_out,
    output logic cs_n_out,
    output logic sdi_out,
    input wire logic sdo_in,
    // Captured data
    output logic [15:0] rx_out
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = 1'b0;
        rx_out = 16'h0000;
    end

    // Clock low before select falls; one select rise per chain
    task automatic send(input logic [15:0] d, input int n, input int slow);
        // Select stays high at least 100 ns between frames
        #103 cs_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi_out = d[i];
            #(32 + slow) sclk_out = 1'b1;
            rx_out = {rx_out[14:0], sdo_in};
            #32 sclk_out = 1'b0;
        end
        #32 sdi_out = ~sdi_out;
        cs_n_out = 1'b1;
    endtask

    // Clock pulses with select high
    task automatic stray(input int n);
        repeat (n) begin
            #32 sclk_out = 1'b1;
            #32 sclk_out = 1'b0;
        end
    endtask
endmodule

// [sim/fsc_top_tb_top.sv]
// Testbench for the filter serial control block.
// Assumes the bound checker and the serial master model.
`timescale 1ns/100ps
module fsc_top_tb_top;
    logic clk, rst, ser_n, g1, pin_g0, sdo, sdo_oe_n, g0_out, g0_oe_n, upd, smode;
    logic m_sclk, m_cs, m_sdi;
    logic [1:0] pin_cut, csel;
    logic [4:0] gdb;
    logic [9:0] rat;
    logic [7:0] word;
    logic [15:0] rx;
    wire logic cut_msb, cut_lsb, g0;
    fsc_pkg::fsc_clk_src_t src;
    fsc_pkg::fsc_clk_ctrl_t mctl;
    fsc_pkg::fsc_settings_t stg;
    int mismatches = 0;
    int tests_run = 0;
    localparam logic [4:0] GDB [4] = '{5'h00, 5'h06, 5'h0C, 5'h18};
    localparam logic [9:0] RAT [4] = '{10'h200, 10'h080, 10'h020, 10'h020};
    localparam logic [3:0] CTL [4] = '{4'hB, 4'h6, 4'h8, 4'hB};
    localparam logic [7:0] WRD [4] = '{8'h81, 8'h52, 8'hE6, 8'h3D};
    localparam fsc_pkg::fsc_clk_src_t SRC [4] = '{fsc_pkg::FSC_SRC_INTERNAL_QUIET,
        fsc_pkg::FSC_SRC_EXTERNAL, fsc_pkg::FSC_SRC_INTERNAL_DRIVE,
        fsc_pkg::FSC_SRC_INTERNAL_QUIET};

    // Shared pins
    assign cut_msb = ser_n ? pin_cut[1] : m_cs;
    assign cut_lsb = ser_n ? pin_cut[0] : m_sclk;
    assign g0 = g0_oe_n ? pin_g0 : g0_out;

    fsc_top u_dut (
        .sys_clk_in(clk), .rst_in(rst), .serial_select_n_in(ser_n),
        .cutoff_code_msb_in(cut_msb), .cutoff_code_lsb_in(cut_lsb),
        .serial_data_in(m_sdi), .serial_data_out(sdo), .serial_data_oe_n_out(sdo_oe_n),
        .gain_code_lsb_in(g0), .gain_code_lsb_out(g0_out),
        .gain_code_lsb_oe_n_out(g0_oe_n), .gain_code_msb_in(g1),
        .clock_source_select_in(csel), .clock_source_out(src),
        .master_clock_ctrl_out(mctl), .filter_settings_out(stg), .gain_db_out(gdb),
        .cutoff_ratio_out(rat), .filter_control_word_out(word),
        .control_update_out(upd), .serial_mode_out(smode)
    );

    fsc_spi_master u_m (
        .sclk_out(m_sclk), .cs_n_out(m_cs), .sdi_out(m_sdi), .sdo_in(sdo), .rx_out(rx)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_upd;
        int n;
        n = 0;
        while (upd !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check(n < 20, 1'b1);
    endtask

    task automatic print_verdict;
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic t_clk;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            csel <= i[1:0];
            tick(5);
            @(negedge clk);
            check(src, SRC[i]);
            check(mctl, CTL[i]);
        end
        $display("clock source test done");
    endtask

    task automatic t_pin;
        logic [1:0] g;
        for (int i = 0; i < 4; i++) begin
            g = 2'h3 - i[1:0];
            @(posedge clk);
            pin_cut <= i[1:0];
            {g1, pin_g0} <= g;
            tick(5);
            @(negedge clk);
            check(stg, {g, i[1:0], 2'h0});
            check(gdb, GDB[g]);
            check(rat, RAT[i]);
            check({sdo_oe_n, g0_oe_n, smode}, 3'h6);
        end
        @(posedge clk);
        pin_cut <= 2'h2;
        $display("pin mode test done");
    endtask

    task automatic t_ser;
        logic [7:0] w;
        @(posedge clk);
        ser_n <= 1'b0;
        tick(6);
        for (int i = 0; i < 4; i++) begin
            w = WRD[i];
            @(posedge clk);
            g1 <= ~g1;
            pin_g0 <= ~pin_g0;
            u_m.send({8'h00, w}, 8, i * 40);
            wait_upd();
            tick(2);
            @(negedge clk);
            check(word, w);
            check(stg, {w[6], w[7], w[4], w[5], w[1], w[0]});
            check(gdb, GDB[{w[6], w[7]}]);
            check(g0, w[0]);
            check({sdo_oe_n, g0_oe_n, smode}, 3'h1);
        end
        $display("serial write test done");
    endtask

    task automatic t_chain;
        u_m.send(16'hC49A, 16, 0);
        wait_upd();
        @(negedge clk);
        check(rx, 16'h3DC4);
        check(word, 8'h9A);
        check(sdo, 1'b1);
        u_m.stray(5);
        tick(4);
        @(negedge clk);
        check(word, 8'h9A);
        check(sdo, 1'b1);
        u_m.send(16'h0000, 8, 0);
        wait_upd();
        check(rx[7:0], 8'h9A);
        check(word, 8'h00);
        check(sdo, 1'b0);
        $display("chain test done");
    endtask

    initial begin
        rst = 1'b1;
        ser_n = 1'b1;
        pin_cut = 2'h2;
        g1 = 1'b0;
        pin_g0 = 1'b0;
        csel = 2'h0;
        tick(7);
        @(negedge clk);
        check(rat, 10'h200);
        @(posedge clk);
        rst <= 1'b0;
        tick(6);
        t_clk();
        t_pin();
        t_ser();
        t_chain();
        print_verdict();
    end

    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end
endmodule
